// *** rtl/frt_fifo.sv ***
// Character FIFO between message builder and line shifter
module frt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int unsigned AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  // Full and empty from pointer difference
  always_comb begin
    level = wp_r - rp_r;
    in_ready = (level != (AW+1)'(DEPTH));
    out_valid = (level != '0);
    out_data = mem_r[rp_r[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  // Pointer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Data array, no reset needed
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

endmodule

// *** rtl/frt_pkg.sv ***
// Package: constants and types for the fastening result transmitter
package frt_pkg;

  // ==========================================================
  // Clock and line rates
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned USB_BPS = 38400;
  localparam int unsigned RS422_BPS = 9600;
  localparam logic [15:0] DIV_USB = 16'(CLK_HZ / USB_BPS);
  localparam logic [15:0] DIV_422 = 16'(CLK_HZ / RS422_BPS);
  localparam logic [3:0] FRAME_BITS = 4'd10;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HLIM = 8'h04;
  localparam logic [7:0] OFS_ALIM = 8'h08;
  localparam logic [7:0] OFS_TORQ = 8'h0c;
  localparam logic [7:0] OFS_HGT = 8'h10;
  localparam logic [7:0] OFS_ANG = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_OPC = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned CTRL_LINK_BIT = 16;
  localparam int unsigned JUDGE_BIT = 31;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_DONE_BIT = 1;
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [11:0] REP_MAX = 12'h005;

  // ==========================================================
  // Characters and message geometry
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [3:0] SEG_LAST = 4'd11;
  localparam logic [3:0] TRL_LAST = 4'd2;
  localparam logic [3:0] START_LAST = 4'd6;

  // ==========================================================
  // Message sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_RES = 3'b100
  } frt_state_type;

endpackage

// *** rtl/frt_tx.sv ***
// Fastening result serial transmitter with APB registers
module frt_tx
  import frt_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial lines
  output logic usb_txd,
  output logic rs422_txd
);

  // ==========================================================
  // Register file
  logic [15:0] freq_r, freq_nxt;
  logic link_r, link_nxt;
  logic [31:0] hlim_r, hlim_nxt, alim_r, alim_nxt, opc_r, opc_nxt;
  logic [31:0] torq_r, torq_nxt, hgt_r, hgt_nxt, ang_r, ang_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic slverr_r, slverr_nxt;
  logic start_pend_r, start_pend_nxt, res_pend_r, res_pend_nxt;
  logic wr_en, setup, hit;
  logic [31:0] rd_mux;
  logic height_on, angle_on;
  logic [1:0] nseg;
  logic take_start, take_res;
  logic [4:0] fifo_level;
  frt_state_type st_r, st_nxt;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = psel && penable;
  assign prdata = prdata_r;
  assign pslverr = slverr_r && pready;

  // Detection enables from the limit pairs
  assign height_on = (hlim_r[15:0] != '0) && (hlim_r[31:16] != '0);
  assign angle_on = (alim_r[15:0] != '0) && (alim_r[31:16] != '0);
  // Layout depends on detection only, never on opc_r
  assign nseg = 2'd1 + 2'(height_on) + 2'(angle_on);

  // Read mux and decode
  always_comb begin
    hit = 1'b1;
    case (paddr)
      OFS_CTRL: rd_mux = {15'h0000, link_r, freq_r};
      OFS_HLIM: rd_mux = hlim_r;
      OFS_ALIM: rd_mux = alim_r;
      OFS_TORQ: rd_mux = torq_r;
      OFS_HGT: rd_mux = hgt_r;
      OFS_ANG: rd_mux = ang_r;
      OFS_CMD: rd_mux = {30'h0000_0000, res_pend_r, start_pend_r};
      OFS_OPC: rd_mux = opc_r;
      OFS_STAT: rd_mux = {22'h00_0000, fifo_level, nseg, st_r};
      default: begin
        rd_mux = ZERO32;
        hit = 1'b0;
      end
    endcase
  end

  // Register next values; pending set wins over take
  always_comb begin
    freq_nxt = freq_r;
    link_nxt = link_r;
    hlim_nxt = hlim_r;
    alim_nxt = alim_r;
    torq_nxt = torq_r;
    hgt_nxt = hgt_r;
    ang_nxt = ang_r;
    opc_nxt = opc_r;
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    start_pend_nxt = start_pend_r && !take_start;
    res_pend_nxt = res_pend_r && !take_res;
    if (setup) begin
      prdata_nxt = pwrite ? ZERO32 : rd_mux;
      slverr_nxt = !hit;
    end
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          freq_nxt = pwdata[15:0];
          link_nxt = pwdata[CTRL_LINK_BIT];
        end
        OFS_HLIM: hlim_nxt = pwdata;
        OFS_ALIM: alim_nxt = pwdata;
        OFS_TORQ: torq_nxt = pwdata;
        OFS_HGT: hgt_nxt = pwdata;
        OFS_ANG: ang_nxt = pwdata;
        OFS_OPC: opc_nxt = pwdata;
        OFS_CMD: begin
          if (pwdata[CMD_START_BIT] && freq_r[15:12] == 4'h1) begin
            start_pend_nxt = 1'b1;
          end
          if (pwdata[CMD_DONE_BIT] && freq_r != FREQ_RST) begin
            res_pend_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_r <= FREQ_RST;
      link_r <= 1'b0;
      hlim_r <= ZERO32;
      alim_r <= ZERO32;
      torq_r <= ZERO32;
      hgt_r <= ZERO32;
      ang_r <= ZERO32;
      opc_r <= ZERO32;
      prdata_r <= ZERO32;
      slverr_r <= 1'b0;
      start_pend_r <= 1'b0;
      res_pend_r <= 1'b0;
    end else begin
      freq_r <= freq_nxt;
      link_r <= link_nxt;
      hlim_r <= hlim_nxt;
      alim_r <= alim_nxt;
      torq_r <= torq_nxt;
      hgt_r <= hgt_nxt;
      ang_r <= ang_nxt;
      opc_r <= opc_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
      start_pend_r <= start_pend_nxt;
      res_pend_r <= res_pend_nxt;
    end
  end

  // ==========================================================
  // Message builder
  logic [20:0] fld_r [3];
  logic [20:0] fld_nxt [3];
  logic [1:0] nseg_r, nseg_nxt, seg_r, seg_nxt;
  logic [11:0] rep_r, rep_nxt;
  logic [3:0] chr_r, chr_nxt;
  logic trl_r, trl_nxt;
  logic push_valid, push_ready;
  logic [7:0] push_data;
  logic [20:0] cur;
  logic [3:0] dig;

  assign take_start = (st_r == ST_IDLE) && start_pend_r;
  assign take_res = (st_r == ST_IDLE) && !start_pend_r && res_pend_r;
  assign push_valid = (st_r != ST_IDLE);
  assign cur = fld_r[seg_r];

  // Character at the current position
  always_comb begin
    dig = 4'h0;
    push_data = CH_SP;
    if (st_r == ST_START) begin
      case (chr_r)
        4'd0: push_data = 8'h53;
        4'd1: push_data = 8'h54;
        4'd2: push_data = 8'h41;
        4'd3: push_data = 8'h52;
        4'd4: push_data = 8'h54;
        4'd5: push_data = CH_CR;
        default: push_data = CH_LF;
      endcase
    end else if (trl_r) begin
      push_data = (chr_r == 4'd0) ? CH_SP : (chr_r == 4'd1) ? CH_CR : CH_LF;
    end else begin
      case (chr_r)
        4'd2, 4'd3, 4'd4, 4'd5, 4'd6: begin
          dig = cur[5'(4'd6 - chr_r) * 4 +: 4];
          push_data = CH_0 + {4'h0, dig};
        end
        4'd9: push_data = cur[20] ? 8'h4f : 8'h4e;
        4'd10: push_data = cur[20] ? 8'h4b : 8'h47;
        default: push_data = CH_SP;
      endcase
    end
  end

  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    seg_nxt = seg_r;
    chr_nxt = chr_r;
    trl_nxt = trl_r;
    rep_nxt = rep_r;
    nseg_nxt = nseg_r;
    fld_nxt = fld_r;
    case (st_r)
      ST_IDLE: begin
        seg_nxt = 2'd0;
        chr_nxt = 4'd0;
        trl_nxt = 1'b0;
        if (take_start) begin
          st_nxt = ST_START;
        end else if (take_res) begin
          // Snapshot settings and results for the whole message
          nseg_nxt = nseg;
          rep_nxt = freq_r[11:0];
          fld_nxt[0] = {torq_r[JUDGE_BIT], torq_r[19:0]};
          fld_nxt[1] = height_on ? {hgt_r[JUDGE_BIT], hgt_r[19:0]}
                                 : {ang_r[JUDGE_BIT], ang_r[19:0]};
          fld_nxt[2] = {ang_r[JUDGE_BIT], ang_r[19:0]};
          // Counts outside one to five send nothing
          if (freq_r[11:0] != '0 && freq_r[11:0] <= REP_MAX) begin
            st_nxt = ST_RES;
          end
        end
      end
      ST_START: begin
        if (push_ready) begin
          chr_nxt = chr_r + 4'd1;
          if (chr_r == START_LAST) begin
            st_nxt = ST_IDLE;
          end
        end
      end
      ST_RES: begin
        if (push_ready) begin
          chr_nxt = chr_r + 4'd1;
          if (trl_r && chr_r == TRL_LAST) begin
            chr_nxt = 4'd0;
            trl_nxt = 1'b0;
            seg_nxt = 2'd0;
            rep_nxt = rep_r - 12'd1;
            if (rep_r == 12'd1) begin
              st_nxt = ST_IDLE;
            end
          end else if (!trl_r && chr_r == SEG_LAST) begin
            chr_nxt = 4'd0;
            if (seg_r == nseg_r - 2'd1) begin
              trl_nxt = 1'b1;
            end else begin
              seg_nxt = seg_r + 2'd1;
            end
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      seg_r <= 2'd0;
      chr_r <= 4'd0;
      trl_r <= 1'b0;
      rep_r <= 12'h000;
      nseg_r <= 2'd1;
      for (int i = 0; i < 3; i++) begin
        fld_r[i] <= 21'h00_0000;
      end
    end else begin
      st_r <= st_nxt;
      seg_r <= seg_nxt;
      chr_r <= chr_nxt;
      trl_r <= trl_nxt;
      rep_r <= rep_nxt;
      nseg_r <= nseg_nxt;
      fld_r <= fld_nxt;
    end
  end

  // ==========================================================
  // FIFO and line shifter
  logic q_valid, q_ready;
  logic [7:0] q_data;
  logic [9:0] sh_r, sh_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [15:0] bcnt_r, bcnt_nxt, div_r, div_nxt;
  logic busy_r, busy_nxt, usb_r, usb_nxt, r422_r, r422_nxt;

  frt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data),
    .level(fifo_level)
  );

  assign q_ready = !busy_r;
  assign usb_txd = usb_r;
  assign rs422_txd = r422_r;

  // Start, 8 data LSB first, stop; rate fixed per frame
  always_comb begin
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    bcnt_nxt = bcnt_r;
    div_nxt = div_r;
    busy_nxt = busy_r;
    if (!busy_r) begin
      if (q_valid) begin
        sh_nxt = {1'b1, q_data, 1'b0};
        div_nxt = link_r ? DIV_422 : DIV_USB;
        bcnt_nxt = 16'h0001;
        bit_nxt = 4'd0;
        busy_nxt = 1'b1;
      end
    end else if (bcnt_r == div_r) begin
      bcnt_nxt = 16'h0001;
      sh_nxt = {1'b1, sh_r[9:1]};
      bit_nxt = bit_r + 4'd1;
      if (bit_r == FRAME_BITS - 4'd1) begin
        busy_nxt = 1'b0;
      end
    end else begin
      bcnt_nxt = bcnt_r + 16'h0001;
    end
    // Unselected line idles high
    usb_nxt = (busy_nxt && !link_r) ? sh_nxt[0] : 1'b1;
    r422_nxt = (busy_nxt && link_r) ? sh_nxt[0] : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= 10'h3ff;
      bit_r <= 4'd0;
      bcnt_r <= 16'h0000;
      div_r <= DIV_USB;
      busy_r <= 1'b0;
      usb_r <= 1'b1;
      r422_r <= 1'b1;
    end else begin
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      bcnt_r <= bcnt_nxt;
      div_r <= div_nxt;
      busy_r <= busy_nxt;
      usb_r <= usb_nxt;
      r422_r <= r422_nxt;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_usb_rate: assert property (!busy_r && q_valid && !link_r |=>
    div_r == DIV_USB && usb_txd == 1'b0 ##1 usb_txd == 1'b0)
    else $error("usb frame rate or start bit wrong");
  chk_rs422_rate: assert property (!busy_r && q_valid && link_r |=>
    div_r == DIV_422 && rs422_txd == 1'b0 && usb_txd == 1'b1)
    else $error("rs422 frame rate or start bit wrong");
  chk_repeat_load: assert property (take_res && freq_r[11:0] == 12'd1 |=>
    rep_r == 12'd1 && st_r == ST_RES)
    else $error("repeat count not loaded");
  chk_height_gate: assert property (hlim_r[15:0] == '0 |-> !height_on)
    else $error("height check with missing limit");
  chk_angle_gate: assert property (alim_r[31:16] == '0 |-> !angle_on)
    else $error("angle check with missing limit");
  chk_layout_one: assert property (take_res && !height_on && !angle_on
    |=> nseg_r == 2'd1)
    else $error("layout one not chosen");
  chk_layout_two: assert property (take_res && (height_on ^ angle_on)
    |=> nseg_r == 2'd2)
    else $error("layout two not chosen");
  chk_layout_three: assert property (take_res && height_on && angle_on
    |=> nseg_r == 2'd3)
    else $error("layout three not chosen");
  chk_zero_silent: assert property (freq_r == FREQ_RST |->
    !$rose(res_pend_r))
    else $error("result queued with zero frequency");
  chk_start_text: assert property (take_start |=>
    st_r == ST_START && push_data == 8'h53)
    else $error("start text not begun");
  chk_digit_range: assert property (st_r == ST_RES && !trl_r &&
    chr_r >= 4'd2 && chr_r <= 4'd6 |-> push_data[7:4] == 4'h3)
    else $error("digit character out of range");
  chk_opc_neutral: assert property ($changed(opc_r) && $stable(hlim_r) &&
    $stable(alim_r) |-> $stable(nseg))
    else $error("operation code changed layout");
  chk_after_done: assert property ($rose(st_r == ST_RES) |->
    $past(res_pend_r))
    else $error("result sent without cycle done");

  cov_layout_three: cover property (take_res && height_on && angle_on);
  cov_start_msg: cover property (take_start);
  cov_fifo_full: cover property (!push_ready);
  cov_rs422_frame: cover property (!busy_r && q_valid && link_r);

endmodule

// *** verif/fastening_result_serial_tx_test.sv ***
// Self-checking bench for the fastening result transmitter
module fastening_result_serial_tx_test
  import frt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals and bookkeeping
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic usb_txd, rs422_txd, usb_stb, rs_stb, usb_ferr, rs_ferr;
  logic [7:0] usb_data, rs_data;
  logic [7:0] usb_q[$];
  logic [7:0] rs_q[$];
  int usb_low, rs_low, fail_count, check_count;

  // ==========================================================
  // Design and one receiver per line
  frt_tx #(.FIFO_DEPTH(16)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_txd(usb_txd), .rs422_txd(rs422_txd));
  frt_rx_model #(.DIV(DIV_USB)) usb_host (.pclk(pclk), .rxd(usb_txd),
    .rx_data(usb_data), .rx_stb(usb_stb), .rx_ferr(usb_ferr));
  frt_rx_model #(.DIV(DIV_422)) plc (.pclk(pclk), .rxd(rs422_txd),
    .rx_data(rs_data), .rx_stb(rs_stb), .rx_ferr(rs_ferr));

  // Clock and input values at time zero
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Collect characters and count low line cycles
  always @(posedge pclk) begin
    if (usb_stb === 1'b1) usb_q.push_back(usb_data);
    if (rs_stb === 1'b1) rs_q.push_back(rs_data);
    if (usb_txd === 1'b0) usb_low++;
    if (rs422_txd === 1'b0) rs_low++;
  end

  // ==========================================================
  // Shared tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r & m, x);
  endtask

  task automatic do_reset(input int settle);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (settle + 1) @(posedge pclk);
    usb_q.delete();
    rs_q.delete();
  endtask

  task automatic wait_len(input bit on_rs, input int n, input int bound);
    int k;
    k = 0;
    while ((on_rs ? rs_q.size() : usb_q.size()) < n && k < bound) begin
      @(posedge pclk);
      k++;
    end
    if (k >= bound) begin
      fail_count++;
      test_done();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_regs();
    logic [31:0] r;
    logic e;
    rdchk(OFS_CTRL, 32'hffff_ffff, ZERO32);
    rdchk(OFS_STAT, 32'hffff_ffff, 32'h0000_0009);
    apb(1'b0, 8'h24, ZERO32, r, e);
    check(32'(e), 32'h0000_0001);
    check(r, ZERO32);
  endtask

  // Frequency 0000 with both checks on: nothing at all
  task automatic s_silent();
    wr(OFS_HLIM, 32'h0001_0009);
    wr(OFS_ALIM, 32'h0001_0009);
    usb_low = 0;
    wr(OFS_CMD, 32'h0000_0003);
    repeat (40) @(posedge pclk);
    rdchk(OFS_CMD, 32'h0000_0003, ZERO32);
    rdchk(OFS_STAT, 32'h0000_0007, 32'h0000_0001);
    check(32'(usb_low), ZERO32);
  endtask

  task automatic s_start();
    string s;
    s = "STA";
    wr(OFS_CTRL, 32'h0000_1001);
    wr(OFS_CMD, 32'h0000_0001);
    wait_len(1'b0, 3, 20000);
    for (int i = 0; i < 3; i++) begin
      check(32'(usb_q[i]), 32'(s[i]));
    end
    check(32'(rs_q.size()), ZERO32);
    do_reset(5400);
  endtask

  // Layout one on USB, start request ignored while leading digit is 0
  task automatic s_usb();
    logic [7:0] x [5];
    x = '{CH_SP, CH_SP, CH_0, CH_0, CH_0 + 8'h01};
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_TORQ, 32'h8000_0100);
    usb_low = 0;
    wr(OFS_CMD, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    check(32'(usb_low), ZERO32);
    wr(OFS_CMD, 32'h0000_0002);
    wait_len(1'b0, 5, 30000);
    for (int i = 0; i < 5; i++) begin
      check(32'(usb_q[i]), 32'(x[i]));
    end
    check(32'(usb_ferr), ZERO32);
    do_reset(5400);
  endtask

  // Field count for each detection pairing, half limits leave it off
  task automatic s_layout();
    logic [31:0] r;
    logic [31:0] x;
    logic e;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_HLIM, i[0] ? 32'h0001_0009 : 32'h0000_0009);
      wr(OFS_ALIM, i[1] ? 32'h0002_0008 : 32'h0002_0000);
      wr(OFS_OPC, 32'(i * 17));
      wr(OFS_CMD, 32'h0000_0002);
      repeat (3) @(posedge pclk);
      apb(1'b0, OFS_STAT, ZERO32, r, e);
      // Field count in bits 4:3, result state in bits 2:0
      x = {27'h0, 2'(1 + i[0] + i[1]), 3'b100};
      check(r & 32'h0000_001f, x);
      do_reset((i == 3) ? 5400 : 0);
    end
  endtask

  task automatic s_rs422();
    wr(OFS_CTRL, 32'h0001_0001);
    usb_low = 0;
    rs_low = 0;
    wr(OFS_CMD, 32'h0000_0002);
    wait_len(1'b1, 1, 25000);
    check(32'(rs_q[0]), 32'(CH_SP));
    // Space: start bit, data bits 0 to 4, 6 and 7 are low
    check(32'(rs_low), 32'(8 * DIV_422));
    check(32'(usb_low), ZERO32);
    check(32'(rs_ferr), ZERO32);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    do_reset(0);
    s_regs();
    s_silent();
    s_start();
    s_usb();
    s_layout();
    s_rs422();
    test_done();
  end
endmodule

// *** verif/frt_rx_model.sv ***
// Serial line receiver model standing for the host PC or PLC
module frt_rx_model #(
  parameter int unsigned DIV = 520
) (
  // Clock
  input wire logic pclk,
  // Serial line
  input wire logic rxd,
  // Received characters
  output logic [7:0] rx_data,
  output logic rx_stb,
  output logic rx_ferr
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Frame receiver
  // Samples at bit centres, LSB first, one stop bit, no parity
  initial begin
    rx_data = 8'h00;
    rx_stb = 1'b0;
    rx_ferr = 1'b0;
    forever begin
      @(negedge rxd);
      repeat (DIV / 2) @(posedge pclk);
      if (rxd === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (DIV) @(posedge pclk);
          rx_data[i] <= rxd;
        end
        repeat (DIV) @(posedge pclk);
        // Sticky flag so a bad stop bit is never missed
        if (rxd !== 1'b1) begin
          rx_ferr <= 1'b1;
        end
        rx_stb <= 1'b1;
        @(posedge pclk);
        rx_stb <= 1'b0;
      end
    end
  end
endmodule
